// ===== common/tsec_pkg.sv
// Constants and a helper function shared by the two-stage event controller
package tsec_pkg;
	localparam int NUM_LEVELS = 16;
	localparam int NUM_GEN = 9;
	localparam int FIRST_GEN = 7;
	localparam int NUM_SRC = 24;
	localparam int FIELD_W = 4;
	localparam int FIELDS_PER_REG = 8;
	localparam int NUM_IAR = 3;
	localparam int REG_W = 32;
	localparam int ADDR_W = 8;
	// Register offsets
	localparam logic [7:0] OFS_PEND_LATCH = 8'h00;
	localparam logic [7:0] OFS_ENABLE_MASK = 8'h04;
	localparam logic [7:0] OFS_ASSIGN0 = 8'h08;
	localparam logic [7:0] OFS_ASSIGN1 = 8'h0c;
	localparam logic [7:0] OFS_ASSIGN2 = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_SOFT_RAISE = 8'h18;
	// Fixed levels
	localparam logic [3:0] LVL_EMULATION = 4'h0;
	localparam logic [3:0] LVL_RESET = 4'h1;
	localparam logic [3:0] LVL_NMI = 4'h2;
	localparam logic [3:0] LVL_EXCEPTION = 4'h3;
	localparam logic [3:0] LVL_RESERVED = 4'h4;
	localparam logic [3:0] LVL_HW_ERROR = 4'h5;
	localparam logic [3:0] LVL_CORE_TICK = 4'h6;
	// Mask bits that always read one or zero, and the bits of the general levels
	localparam logic [15:0] MASK_FORCED_ONE = 16'h0007;
	localparam logic [15:0] LATCH_VALID_BITS = 16'hffef;
	localparam logic [15:0] GEN_LEVEL_BITS = 16'hff80;
	// Reset values
	localparam logic [15:0] RST_PEND_LATCH = 16'h0000;
	localparam logic [15:0] RST_ENABLE_MASK = 16'h0007;
	localparam logic [31:0] RST_ASSIGN0 = 32'h10000000;
	localparam logic [31:0] RST_ASSIGN1 = 32'h33322221;
	localparam logic [31:0] RST_ASSIGN2 = 32'h66655444;
	localparam logic RST_GLOBAL_EN = 1'b0;

	function automatic logic [4:0] tsec_lowest(input logic [15:0] v);
		logic [4:0] r;
		r = 5'h10;
		for (int i = NUM_LEVELS - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = 5'(i);
			end
		end
		return r;
	endfunction : tsec_lowest
endpackage : tsec_pkg

// ===== core/tsec_router.sv
// System routing stage: peripheral sources onto general levels
`timescale 1ns/1ns
module tsec_router #(
	parameter int NSRC = tsec_pkg::NUM_SRC
) (
	input wire logic [NSRC-1:0] periph_irq,
	input wire logic [tsec_pkg::NUM_IAR*32-1:0] assign_regs,
	output logic [tsec_pkg::NUM_GEN-1:0] gen_req
);
	import tsec_pkg::*;

	if (NSRC < 1 || NSRC > NUM_IAR * FIELDS_PER_REG) begin : g_bad_nsrc
		$error("tsec_router: too many sources for assignment fields");
	end

	always_comb begin
		logic [3:0] f;
		f = 4'h0;
		gen_req = '0;
		for (int s = 0; s < NSRC; s++) begin
			f = assign_regs[s*FIELD_W +: FIELD_W];
			// Field n selects level 7+n; out-of-range values route nowhere
			if (periph_irq[s] && (int'(f) < NUM_GEN)) begin
				gen_req[f] = 1'b1;
			end
		end
	end
endmodule : tsec_router

// ===== core/tsec_prio.sv
// Core priority stage: picks the winning enabled event
`timescale 1ns/1ns
module tsec_prio (
	input wire logic [15:0] latch,
	input wire logic [15:0] mask,
	input wire logic global_en,
	input wire logic [15:0] in_service,
	output logic req,
	output logic [3:0] level
);
	import tsec_pkg::*;

	logic [15:0] cand;
	logic [4:0] win;
	logic [4:0] busy;

	always_comb begin
		cand = latch & mask & LATCH_VALID_BITS;
		if (!global_en) begin
			cand = cand & ~GEN_LEVEL_BITS;
		end
		win = tsec_lowest(cand);
		busy = tsec_lowest(in_service);
		// Only preempt a handler of lower priority
		req = (win < busy);
		level = win[3:0];
	end
endmodule : tsec_prio

// ===== core/tsec_top.sv
// Two-stage event controller: routing, latching, masking and hand-off
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
module tsec_top #(
	parameter int NSRC = tsec_pkg::NUM_SRC
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [tsec_pkg::ADDR_W-1:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [31:0] bus_rdata,
	input wire logic supervisor,
	input wire logic [NSRC-1:0] periph_irq,
	input wire logic emulation_event,
	input wire logic reset_event,
	input wire logic nmi_event,
	input wire logic exception_event,
	input wire logic hardware_error_event,
	input wire logic core_tick_event,
	input wire logic global_enable_instruction,
	input wire logic global_disable_instruction,
	output logic event_req,
	output logic [3:0] event_level,
	input wire logic event_accept,
	input wire logic [31:0] return_pc,
	input wire logic [31:0] state_word,
	output logic stack_push,
	output logic [31:0] stack_data,
	input wire logic return_instruction,
	input wire logic [3:0] return_level,
	output logic resume_valid,
	output logic [31:0] resume_addr
);
	import tsec_pkg::*;

	if (NSRC < 1 || NSRC > NUM_IAR * FIELDS_PER_REG) begin : g_bad_nsrc
		$error("tsec_top: source count out of range");
	end

	typedef struct packed {
		logic [15:0] latch;
		logic [15:0] mask;
		logic [NUM_IAR*32-1:0] assign_regs;
		logic global_en;
		logic [15:0] in_service;
		logic [15:0] prev_in;
		logic [15:0][31:0] ret_addr;
		logic [31:0] rdata;
		logic push;
		logic [31:0] push_data;
		logic resume;
		logic [31:0] resume_data;
	} tsec_state_type;

	tsec_state_type st_reg;
	tsec_state_type st_next;

	logic [NUM_GEN-1:0] gen_req;
	logic [15:0] event_in;
	logic [15:0] set_vec;
	logic acc_fire;
	logic prio_req;
	logic [3:0] prio_level;

	tsec_router #(
		.NSRC(NSRC)
	) u_router (
		.periph_irq(periph_irq),
		.assign_regs(st_reg.assign_regs),
		.gen_req(gen_req)
	);

	tsec_prio u_prio (
		.latch(st_reg.latch),
		.mask(st_reg.mask),
		.global_en(st_reg.global_en),
		.in_service(st_reg.in_service),
		.req(prio_req),
		.level(prio_level)
	);

	// Dedicated inputs at fixed levels, general levels above them
	always_comb begin
		event_in = '0;
		event_in[LVL_EMULATION] = emulation_event;
		event_in[LVL_RESET] = reset_event;
		event_in[LVL_NMI] = nmi_event;
		event_in[LVL_EXCEPTION] = exception_event;
		event_in[LVL_HW_ERROR] = hardware_error_event;
		event_in[LVL_CORE_TICK] = core_tick_event;
		event_in[15:FIRST_GEN] = gen_req;
	end

	assign set_vec = event_in & ~st_reg.prev_in & LATCH_VALID_BITS;
	assign event_req = prio_req;
	assign event_level = prio_level;
	assign acc_fire = event_accept && prio_req;

	always_comb begin
		logic [15:0] clr;
		logic [15:0] raise;
		clr = '0;
		raise = '0;
		st_next = st_reg;
		st_next.prev_in = event_in;
		st_next.push = 1'b0;
		st_next.resume = 1'b0;
		st_next.rdata = '0;
		// Register writes
		if (bus_wr && supervisor) begin
			unique case (bus_addr)
				OFS_PEND_LATCH: begin
					// Ones cancel latched events whose mask bit is clear
					clr = bus_wdata[15:0] & ~st_reg.mask;
				end
				OFS_ENABLE_MASK: begin
					st_next.mask = (bus_wdata[15:0] | MASK_FORCED_ONE)
						& LATCH_VALID_BITS;
				end
				OFS_ASSIGN0: begin
					st_next.assign_regs[31:0] = bus_wdata;
				end
				OFS_ASSIGN1: begin
					st_next.assign_regs[63:32] = bus_wdata;
				end
				OFS_ASSIGN2: begin
					st_next.assign_regs[95:64] = bus_wdata;
				end
				OFS_SOFT_RAISE: begin
					raise = bus_wdata[15:0] & GEN_LEVEL_BITS;
				end
				default: begin
				end
			endcase
		end
		// Register reads, supervisor only
		if (bus_rd && supervisor) begin
			unique case (bus_addr)
				OFS_PEND_LATCH: st_next.rdata = {16'h0000, st_reg.latch};
				OFS_ENABLE_MASK: st_next.rdata = {16'h0000, st_reg.mask};
				OFS_ASSIGN0: st_next.rdata = st_reg.assign_regs[31:0];
				OFS_ASSIGN1: st_next.rdata = st_reg.assign_regs[63:32];
				OFS_ASSIGN2: st_next.rdata = st_reg.assign_regs[95:64];
				OFS_STATUS: begin
					st_next.rdata = {10'h000, st_reg.global_en,
						st_reg.in_service, prio_req, prio_level};
				end
				default: st_next.rdata = '0;
			endcase
		end
		// Acceptance: clear latch, mark in service, save state
		if (acc_fire) begin
			clr[prio_level] = 1'b1;
			st_next.in_service[prio_level] = 1'b1;
			st_next.ret_addr[prio_level] = return_pc;
			st_next.push = 1'b1;
			st_next.push_data = state_word;
		end
		// Return from event
		if (return_instruction) begin
			st_next.in_service[return_level] = 1'b0;
			st_next.resume = 1'b1;
			st_next.resume_data = st_reg.ret_addr[return_level];
			if (acc_fire && (return_level == prio_level)) begin
				st_next.in_service[return_level] = 1'b1;
			end
		end
		// New captures win over clears in the same cycle
		st_next.latch = ((st_reg.latch & ~clr) | set_vec | raise)
			& LATCH_VALID_BITS;
		if (global_enable_instruction) begin
			st_next.global_en = 1'b1;
		end else if (global_disable_instruction) begin
			st_next.global_en = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			st_reg <= '0;
			st_reg.latch <= RST_PEND_LATCH;
			st_reg.mask <= RST_ENABLE_MASK;
			// Default routing of all sources
			st_reg.assign_regs <= {RST_ASSIGN2, RST_ASSIGN1, RST_ASSIGN0};
			st_reg.global_en <= RST_GLOBAL_EN;
		end else begin
			st_reg <= st_next;
		end
	end

	assign bus_rdata = st_reg.rdata;
	assign stack_push = st_reg.push;
	assign stack_data = st_reg.push_data;
	assign resume_valid = st_reg.resume;
	assign resume_addr = st_reg.resume_data;

	// Checks
	logic [15:0] open_cand;
	logic [15:0] higher_pend;
	logic [4:0] svc_top;
	// Latched, unmasked and enabled events as software sees them
	assign open_cand = st_reg.latch & st_reg.mask & LATCH_VALID_BITS
		& ~({16{~st_reg.global_en}} & GEN_LEVEL_BITS);
	assign higher_pend = open_cand
		& ((16'h0001 << event_level) - 16'h0001);
	assign svc_top = tsec_lowest(st_reg.in_service);

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);

	// Core takes the offered event
	sequence s_take;
		acc_fire;
	endsequence

	// Return from the level that was taken three cycles before
	sequence s_return_same;
		return_instruction && (return_level == $past(event_level, 3));
	endsequence

	property p_resume;
		s_take ##3 s_return_same
			|=> resume_valid && (resume_addr == $past(return_pc, 4));
	endproperty

	a_resume_address: assert property (p_resume)
		else $error("resume address differs from saved pc");

	a_resume_pulse: assert property (
		resume_valid == $past(return_instruction))
		else $error("resume pulse does not follow return");

	a_return_clears: assert property (return_instruction
		&& !acc_fire |=> !st_reg.in_service[$past(return_level)])
		else $error("level still in service after return");

	a_state_push: assert property (s_take |=> stack_push
		&& stack_data == $past(state_word))
		else $error("state not pushed on acceptance");

	a_push_pulse: assert property (
		stack_push == $past(acc_fire))
		else $error("state push without acceptance");

	a_accept_clears: assert property (acc_fire
		&& !set_vec[event_level]
		&& !(bus_wr && bus_addr == OFS_SOFT_RAISE)
		|=> !st_reg.latch[$past(event_level)])
		else $error("latch bit not cleared on acceptance");

	a_accept_service: assert property (acc_fire
		&& !return_instruction
		|=> st_reg.in_service[$past(event_level)])
		else $error("accepted level not marked in service");

	a_capture_sets: assert property ((set_vec != 16'h0000)
		|=> ((st_reg.latch & $past(set_vec)) == $past(set_vec)))
		else $error("captured event not latched");

	a_raise_sets: assert property (bus_wr && supervisor
		&& bus_addr == OFS_SOFT_RAISE
		|=> (st_reg.latch & $past(bus_wdata[15:0] & GEN_LEVEL_BITS))
			== $past(bus_wdata[15:0] & GEN_LEVEL_BITS))
		else $error("raised level not latched");

	// Software cancel on each level whose mask bit is clear
	for (genvar g = 0; g < NUM_LEVELS; g++) begin : g_cancel
		a_cancel_level: assert property (bus_wr && supervisor
			&& bus_addr == OFS_PEND_LATCH && bus_wdata[g]
			&& !st_reg.mask[g] && !set_vec[g] |=> !st_reg.latch[g])
			else $error("latched event not cancelled");
	end

	a_latch_protect: assert property (bus_wr
		&& bus_addr == OFS_PEND_LATCH && !supervisor && !acc_fire
		|=> ((st_reg.latch & $past(st_reg.latch))
			== $past(st_reg.latch)))
		else $error("latch changed by user-mode write");

	a_read_quiet: assert property (
		!(bus_rd && supervisor) |=> bus_rdata == 32'h00000000)
		else $error("read data outside a supervisor read");

	a_mask_gates: assert property (
		event_req |-> st_reg.mask[event_level])
		else $error("masked event presented");

	a_mask_forced: assert property (
		(st_reg.mask & MASK_FORCED_ONE) == MASK_FORCED_ONE)
		else $error("nonmaskable level lost its mask bit");

	a_mask_read: assert property (bus_rd && supervisor
		&& bus_addr == OFS_ENABLE_MASK
		|=> bus_rdata == {16'h0000, $past(st_reg.mask)})
		else $error("mask read back wrong");

	a_user_mask: assert property (bus_wr && !supervisor
		&& bus_addr == OFS_ENABLE_MASK
		|=> st_reg.mask == $past(st_reg.mask))
		else $error("mask changed by user-mode write");

	a_global_gate: assert property (event_req
		&& event_level >= 4'(FIRST_GEN) |-> st_reg.global_en)
		else $error("general level presented while disabled");

	a_enable_set: assert property (
		global_enable_instruction |=> st_reg.global_en)
		else $error("global enable not set");

	a_enable_clear: assert property (global_disable_instruction
		&& !global_enable_instruction |=> !st_reg.global_en)
		else $error("global enable not cleared");

	a_reserved_quiet: assert property (
		event_req |-> event_level != LVL_RESERVED)
		else $error("reserved level presented");

	a_lowest_wins: assert property (event_req
		|-> higher_pend == 16'h0000 && {1'b0, event_level} < svc_top)
		else $error("higher priority event bypassed");

	a_default_map: assert property ($rose(resetn)
		|-> st_reg.assign_regs == {RST_ASSIGN2, RST_ASSIGN1, RST_ASSIGN0})
		else $error("routing not at default after reset");

	a_route_level: assert property (periph_irq[0]
		&& st_reg.assign_regs[3:0] == 4'h0 |-> gen_req[0])
		else $error("source not routed to its level");
endmodule : tsec_top

// ===== verif/tsec_core_model.sv
// Processor core model: takes offered events, supplies pc and state
`timescale 1ns/1ns
module tsec_core_model (
	input wire logic clock,
	input wire logic resetn,
	input wire logic accept_en,
	input wire logic [3:0] delay,
	input wire logic event_req,
	input wire logic [3:0] event_level,
	output logic event_accept,
	output logic [31:0] return_pc,
	output logic [31:0] state_word
);
	logic [3:0] wait_reg;
	always_ff @(posedge clock) begin
		if (!resetn) begin
			event_accept <= 1'b0;
			wait_reg <= 4'h0;
			return_pc <= 32'h0;
			state_word <= 32'h0;
		end else begin
			event_accept <= 1'b0;
			// Junk outside acceptance
			return_pc <= ~return_pc;
			state_word <= ~state_word;
			if (accept_en && event_req && !event_accept) begin
				if (wait_reg == delay) begin
					event_accept <= 1'b1;
					return_pc <= {28'h0000100, event_level};
					state_word <= {28'h00005a0, event_level};
					wait_reg <= 4'h0;
				end else begin
					wait_reg <= wait_reg + 4'h1;
				end
			end else begin
				wait_reg <= 4'h0;
			end
		end
	end
endmodule : tsec_core_model

// ===== verif/tsec_tb_top.sv
// Testbench for the two-stage event controller
`timescale 1ns/1ns
module tsec_tb_top;
	import tsec_pkg::*;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] bus_addr = 8'h00;
	logic [31:0] bus_wdata = 32'h0;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic supervisor = 1'b1;
	logic [23:0] periph_irq = 24'h0;
	logic [7:0] ded = 8'h00;
	logic ret_ins = 1'b0;
	logic [3:0] ret_lvl = 4'h0;
	logic acc_en = 1'b0;
	logic [3:0] delay = 4'h0;
	logic [31:0] bus_rdata, return_pc, state_word, stack_data, resume_addr;
	logic event_req, event_accept, stack_push, resume_valid;
	logic [3:0] event_level;
	int fails = 0;
	int tests_run = 0;
	always #50 clock = ~clock;
	tsec_top dut (.clock(clock), .resetn(resetn), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_rdata(bus_rdata), .supervisor(supervisor),
		.periph_irq(periph_irq), .emulation_event(ded[0]),
		.reset_event(ded[1]), .nmi_event(ded[2]), .exception_event(ded[3]),
		.hardware_error_event(ded[4]), .core_tick_event(ded[5]),
		.global_enable_instruction(ded[6]),
		.global_disable_instruction(ded[7]), .event_req(event_req),
		.event_level(event_level), .event_accept(event_accept),
		.return_pc(return_pc), .state_word(state_word),
		.stack_push(stack_push), .stack_data(stack_data),
		.return_instruction(ret_ins), .return_level(ret_lvl),
		.resume_valid(resume_valid), .resume_addr(resume_addr));
	tsec_core_model core (.clock(clock), .resetn(resetn),
		.accept_en(acc_en), .delay(delay), .event_req(event_req),
		.event_level(event_level), .event_accept(event_accept),
		.return_pc(return_pc), .state_word(state_word));
	task automatic close_out();
		$display("Checks %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : close_out
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge clock);
		bus_wr <= 1'b0;
	endtask : wr
	task automatic rdc(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		@(posedge clock);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge clock);
		bus_rd <= 1'b0;
		#1;
		chk(nm, bus_rdata, e);
	endtask : rdc
	task automatic irq(input int s);
		@(posedge clock);
		periph_irq[s] <= 1'b1;
		@(posedge clock);
		periph_irq[s] <= 1'b0;
	endtask : irq
	task automatic dp(input int i);
		@(posedge clock);
		ded[i] <= 1'b1;
		@(posedge clock);
		ded[i] <= 1'b0;
	endtask : dp
	task automatic idle(input string nm);
		repeat (3) @(posedge clock);
		#1;
		chk(nm, {31'h0, event_req}, 32'h0);
	endtask : idle
	task automatic take(input logic [3:0] l);
		int n;
		n = 0;
		#1;
		while (event_req !== 1'b1 && n < 20) begin
			@(posedge clock);
			#1;
			n++;
		end
		if (n == 20) begin
			fails++;
			close_out();
		end
		chk("event_level", {28'h0, event_level}, {28'h0, l});
		@(posedge clock);
		acc_en <= 1'b1;
		n = 0;
		while (stack_push !== 1'b1 && n < 20) begin
			@(posedge clock);
			#1;
			n++;
		end
		if (n == 20) begin
			fails++;
			close_out();
		end
		chk("stack_data", stack_data, {28'h00005a0, l});
		@(posedge clock);
		acc_en <= 1'b0;
	endtask : take
	task automatic give(input logic [3:0] l);
		@(posedge clock);
		ret_ins <= 1'b1;
		ret_lvl <= l;
		@(posedge clock);
		ret_ins <= 1'b0;
		#1;
		chk("resume_valid", {31'h0, resume_valid}, 32'h1);
		chk("resume_addr", resume_addr, {28'h0000100, l});
	endtask : give
	task automatic serve(input logic [3:0] l);
		take(l);
		give(l);
	endtask : serve
	function automatic logic [3:0] dl(input int s);
		return 4'(s < 7 ? 7 : s < 9 ? 8 : s < 13 ? 9 : s < 16 ? 10 :
			s < 19 ? 11 : s < 21 ? 12 : 13);
	endfunction : dl
	task automatic t_reset();
		rdc("latch", OFS_PEND_LATCH, 32'h0);
		rdc("mask", OFS_ENABLE_MASK, 32'h7);
		rdc("assign0", OFS_ASSIGN0, 32'h10000000);
		rdc("assign1", OFS_ASSIGN1, 32'h33322221);
		rdc("assign2", OFS_ASSIGN2, 32'h66655444);
		rdc("unmapped", 8'hf0, 32'h0);
	endtask : t_reset
	task automatic t_global();
		logic [3:0] lv[6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6};
		wr(OFS_ENABLE_MASK, 32'hffff);
		rdc("mask", OFS_ENABLE_MASK, 32'hffef);
		irq(0);
		idle("gen_off");
		for (int i = 0; i < 6; i++) begin
			dp(i);
			serve(lv[i]);
		end
		dp(6);
		serve(4'h7);
		dp(7);
		irq(0);
		idle("gen_off2");
		dp(6);
		serve(4'h7);
	endtask : t_global
	task automatic t_mask();
		wr(OFS_ENABLE_MASK, 32'h0);
		rdc("mask", OFS_ENABLE_MASK, 32'h7);
		irq(0);
		idle("masked");
		rdc("latch", OFS_PEND_LATCH, 32'h80);
		wr(OFS_PEND_LATCH, 32'h80);
		rdc("cancel", OFS_PEND_LATCH, 32'h0);
		irq(0);
		wr(OFS_ENABLE_MASK, 32'h80);
		wr(OFS_PEND_LATCH, 32'h80);
		rdc("nocancel", OFS_PEND_LATCH, 32'h80);
		serve(4'h7);
		rdc("latch", OFS_PEND_LATCH, 32'h0);
		irq(7);
		@(posedge clock);
		supervisor <= 1'b0;
		rdc("user_rd", OFS_ENABLE_MASK, 32'h0);
		wr(OFS_ENABLE_MASK, 32'h0);
		wr(OFS_PEND_LATCH, 32'h100);
		@(posedge clock);
		supervisor <= 1'b1;
		rdc("user_wr", OFS_ENABLE_MASK, 32'h87);
		rdc("user_clr", OFS_PEND_LATCH, 32'h100);
		wr(OFS_PEND_LATCH, 32'h100);
		rdc("clear8", OFS_PEND_LATCH, 32'h0);
		wr(OFS_ENABLE_MASK, 32'hffff);
	endtask : t_mask
	task automatic t_route();
		for (int s = 0; s < 24; s++) begin
			@(posedge clock);
			delay <= 4'(s % 4);
			irq(s);
			serve(dl(s));
		end
	endtask : t_route
	task automatic t_prio();
		irq(9);
		irq(7);
		take(4'h8);
		idle("blocked");
		dp(2);
		serve(4'h2);
		give(4'h8);
		serve(4'h9);
	endtask : t_prio
	task automatic t_assign();
		wr(OFS_ASSIGN0, 32'h10000006);
		rdc("assign0", OFS_ASSIGN0, 32'h10000006);
		irq(0);
		serve(4'hd);
		wr(OFS_ASSIGN0, 32'h10000000);
		wr(OFS_SOFT_RAISE, 32'h0000c000);
		rdc("status", OFS_STATUS, 32'h0020001e);
		serve(4'he);
		serve(4'hf);
	endtask : t_assign
	initial begin
		repeat (16) @(posedge clock);
		resetn <= 1'b1;
		t_reset();
		t_global();
		t_mask();
		t_route();
		t_prio();
		t_assign();
		close_out();
	end
endmodule : tsec_tb_top
